/* File: bench/adc_correction_asserts.sv */
module adc_correction_asserts
	import adc_correction_pkg::*;
(
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	input wire logic I_CAPTURE_HOLD,
	input wire logic [RESULT_BITS-1:0] O_RESULT,
	input wire logic O_RESULT_VALID,
	input wire logic O_PHASE_ONE,
	input wire logic O_PHASE_TWO,
	input wire logic [STAGE_COUNT-1:0] O_STAGE_SAMPLE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RESET);
	sequence s_fill;
		!O_RESULT_VALID [*7] ##1 O_RESULT_VALID;
	endsequence
	sequence s_run;
		O_RESULT_VALID ##1 !I_CAPTURE_HOLD [*4];
	endsequence
	// Margin of five covers the synchroniser lag
	sequence s_held;
		O_RESULT_VALID ##0 I_CAPTURE_HOLD [*5];
	endsequence
	AST_LATENCY: assert property ($fell(I_RESET) |-> s_fill)
		else $error("first result late or early");
	AST_GAPLESS: assert property (s_run |-> O_RESULT_VALID)
		else $error("gap in result stream");
	AST_FREEZE: assert property (s_held |=> $stable(O_RESULT))
		else $error("result moved while held");
	AST_EXCL: assert property (!(O_PHASE_ONE && O_PHASE_TWO))
		else $error("phases overlap");
	AST_ALT_ONE: assert property (O_PHASE_ONE |=> O_PHASE_TWO)
		else $error("phase two missing");
	AST_ALT_TWO: assert property (O_PHASE_TWO |=> O_PHASE_ONE)
		else $error("phase one missing");
	AST_START: assert property ($fell(I_RESET) |=> O_PHASE_ONE && O_STAGE_SAMPLE == 8'h55)
		else $error("bad first phase");
	AST_STAGES: assert property (O_STAGE_SAMPLE == {4{O_PHASE_TWO, O_PHASE_ONE}})
		else $error("stage phases not alternating");
	AST_RUNNING: assert property (O_RESULT_VALID |-> O_PHASE_ONE || O_PHASE_TWO)
		else $error("no phase while running");
endmodule : adc_correction_asserts

bind adc_correction adc_correction_asserts u_asserts (.*);

/* File: bench/result_capture.sv */
module result_capture
	import adc_correction_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_stall,
	input wire logic [RESULT_BITS-1:0] i_result,
	input wire logic i_valid,
	output logic o_hold = 1'b0,
	output logic o_take,
	output logic [RESULT_BITS-1:0] o_word
);
	timeunit 1ns;
	timeprecision 1ps;
	int age;
	always @(posedge i_clock) begin
		o_hold <= i_stall && !i_reset;
		age <= i_reset ? 0 : (age < WARMUP_CYCLES ? age + 1 : age);
	end
	// Held words stand several cycles, so none is taken then
	assign o_take = i_valid && !o_hold && age >= WARMUP_CYCLES;
	assign o_word = i_result;
endmodule : result_capture

/* File: bench/tb_top.sv */
module tb_top
	import adc_correction_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SKIP = WARMUP_CYCLES - LATENCY_CYCLES;
	logic clk = 0, rst = 1, fmt = 0, stall = 0;
	logic [15:0] stages = '0;
	logic [1:0] flash = '0;
	logic [9:0] res, word;
	logic vld, rdy, hold, take;
	logic [17:0] samp [64];
	logic [9:0] exp_q [$];
	int mismatches = 0, compares = 0, cycles = 0;
	initial forever #12.5 clk = ~clk;
	adc_correction #(.FIFO_ENTRIES(4)) u_dut (.I_CLOCK(clk), .I_RESET(rst),
		.I_STAGE_WORDS(stages), .I_FLASH_WORD(flash), .I_OUTPUT_FORMAT_SELECT(fmt),
		.I_CAPTURE_HOLD(hold), .O_RESULT(res), .O_RESULT_VALID(vld), .O_BUFFER_READY(rdy),
		.O_PHASE_ONE(), .O_PHASE_TWO(), .O_STAGE_SAMPLE());
	result_capture u_cap (.i_clock(clk), .i_reset(rst), .i_stall(stall), .i_result(res),
		.i_valid(vld), .o_hold(hold), .o_take(take), .o_word(word));
	task complete_run();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task check_value(input logic [9:0] got, input logic [9:0] want);
		compares++;
		if (got !== want) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask : check_value
	function automatic logic [9:0] expect_of(input logic [17:0] v, input logic f);
		logic [10:0] sum;
		sum = '0;
		for (int m = 0; m < 9; m++) sum += 11'(v[2*m +: 2]) << (8 - m);
		return (sum > 11'h3ff ? 10'h3ff : sum[9:0]) ^ (f ? MSB_FLIP : 10'h000);
	endfunction : expect_of
	task run_test(input int n, input logic f, input int hold_at);
		fmt <= f;
		stall <= 1'b0;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		for (int s = 0; s < 64; s++)
			samp[s] = s < 2 ? {18{s[0]}} : (s < n ? 18'($urandom) : '0);
		// Words before warm-up are ignored by the capture side
		for (int s = SKIP; s < n && hold_at == 0; s++) exp_q.push_back(expect_of(samp[s], f));
		rst <= 1'b0;
		for (int c = 0; c < n + 12; c++) begin
			for (int m = 0; m < 8; m++)
				stages[2*m +: 2] <= c >= m/2 ? samp[c - m/2][2*m +: 2] : 2'h0;
			flash <= c >= 4 ? samp[c - 4][17:16] : 2'h0;
			stall <= hold_at > 0 && c >= hold_at && c < hold_at + 12;
			if (hold_at > 0 && (c == hold_at || c == hold_at + 12))
				check_value(10'(rdy), 10'(c == hold_at));
			@(posedge clk);
		end
		check_value(10'(exp_q.size()), 10'h000);
		exp_q.delete();
	endtask : run_test
	always @(posedge clk)
		if (take && exp_q.size() > 0)
			check_value(word, exp_q.pop_front());
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(11));
		for (int t = 0; t < 3; t++) begin
			run_test(40, t == 1 ? 1'b1 : 1'($urandom), t == 2 ? 20 : 0);
			$display("test %0d done", t);
		end
		complete_run();
	end
endmodule : tb_top

/* File: common/adc_correction_pkg.sv */
package adc_correction_pkg;
	localparam int STAGE_COUNT = 8;
	localparam int WORD_BITS = 2;
	localparam int RESULT_BITS = 10;
	localparam int VECTOR_BITS = (STAGE_COUNT + 1) * WORD_BITS;
	localparam int SUM_BITS = RESULT_BITS + 1;
	localparam int ALIGN_DEPTH = STAGE_COUNT / 2;
	localparam int FIFO_WIDTH = RESULT_BITS;
	localparam int FIFO_DEPTH = 16;
	localparam int LATENCY_CYCLES = 7;
	localparam int WARMUP_CYCLES = 20;
	localparam int CLOCK_PERIOD_NS = 25;
	localparam logic [RESULT_BITS-1:0] RESULT_RESET = 10'h000;
	localparam logic [RESULT_BITS-1:0] RESULT_MAX = 10'h3ff;
	localparam logic [RESULT_BITS-1:0] MSB_FLIP = 10'h200;
	localparam logic [WORD_BITS-1:0] WORD_RESET = 2'h0;
	typedef enum logic [1:0] {
		PHASE_IDLE,
		PHASE_SAMPLE,
		PHASE_AMPLIFY
	} phase_type;
endpackage : adc_correction_pkg

/* File: logic/adc_correction.sv */

module adc_result_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_push_valid,
	output logic o_push_ready,
	input wire logic [WIDTH-1:0] i_push_data,
	output logic o_pop_valid,
	input wire logic i_pop_ready,
	output logic [WIDTH-1:0] o_pop_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic [AW:0] next_wr_ptr;
	logic [AW:0] next_rd_ptr;
	logic full;
	logic empty;
	logic push;
	logic pop;

	// Full when the indexes meet but the wrap bits differ
	always_comb begin
		full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
		empty = (wr_ptr == rd_ptr);
		o_push_ready = !full;
		o_pop_valid = !empty;
		o_pop_data = mem[rd_ptr[AW-1:0]];
		push = i_push_valid && !full;
		pop = i_pop_ready && !empty;
	end

	always_comb begin
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push) begin
			next_mem[wr_ptr[AW-1:0]] = i_push_data;
			next_wr_ptr = wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = rd_ptr + 1'b1;
		end
	end

	// Storage left unreset; only pointers carry control meaning
	always_ff @(posedge i_clock) begin
		mem <= next_mem;
		if (i_reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end
endmodule : adc_result_fifo

module adc_correction
	import adc_correction_pkg::*;
#(
	parameter int FIFO_ENTRIES = FIFO_DEPTH
) (
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	input wire logic [STAGE_COUNT*WORD_BITS-1:0] I_STAGE_WORDS,
	input wire logic [WORD_BITS-1:0] I_FLASH_WORD,
	input wire logic I_OUTPUT_FORMAT_SELECT,
	input wire logic I_CAPTURE_HOLD,
	output logic [RESULT_BITS-1:0] O_RESULT,
	output logic O_RESULT_VALID,
	output logic O_BUFFER_READY,
	output logic O_PHASE_ONE,
	output logic O_PHASE_TWO,
	output logic [STAGE_COUNT-1:0] O_STAGE_SAMPLE
);
	// Pin synchronisers; both pins are levels, so the two-cycle lag loses nothing
	logic fmt_meta;
	logic fmt_sync;
	logic hold_meta;
	logic hold_sync;
	logic next_fmt_meta;
	logic next_fmt_sync;
	logic next_hold_meta;
	logic next_hold_sync;

	always_comb begin
		next_fmt_meta = I_OUTPUT_FORMAT_SELECT;
		next_fmt_sync = fmt_meta;
		next_hold_meta = I_CAPTURE_HOLD;
		next_hold_sync = hold_meta;
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			fmt_meta <= 1'b0;
			fmt_sync <= 1'b0;
			hold_meta <= 1'b0;
			hold_sync <= 1'b0;
		end else begin
			fmt_meta <= next_fmt_meta;
			fmt_sync <= next_fmt_sync;
			hold_meta <= next_hold_meta;
			hold_sync <= next_hold_sync;
		end
	end

	// Two-phase sampling clock; idle state keeps both phases low
	phase_type phase;
	phase_type next_phase;
	logic next_phase_one;
	logic next_phase_two;
	logic [STAGE_COUNT-1:0] next_stage_sample;

	always_comb begin
		case (phase)
			PHASE_IDLE: begin
				next_phase = PHASE_SAMPLE;
			end
			PHASE_SAMPLE: begin
				next_phase = PHASE_AMPLIFY;
			end
			PHASE_AMPLIFY: begin
				next_phase = PHASE_SAMPLE;
			end
			default: begin
				next_phase = PHASE_IDLE;
			end
		endcase
		// Decoded from the next state so both phases leave flip-flops together
		next_phase_one = (next_phase == PHASE_SAMPLE);
		next_phase_two = (next_phase == PHASE_AMPLIFY);
		// Even stages sample while odd stages amplify
		for (int m = 0; m < STAGE_COUNT; m++) begin
			next_stage_sample[m] = (m % 2 == 0) ? next_phase_one : next_phase_two;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			phase <= PHASE_IDLE;
			O_PHASE_ONE <= 1'b0;
			O_PHASE_TWO <= 1'b0;
			O_STAGE_SAMPLE <= '0;
		end else begin
			phase <= next_phase;
			O_PHASE_ONE <= next_phase_one;
			O_PHASE_TWO <= next_phase_two;
			O_STAGE_SAMPLE <= next_stage_sample;
		end
	end

	// Stage m word arrives m/2 cycles after its sample, flash word after four
	logic [VECTOR_BITS-1:0] aligned;
	assign aligned[WORD_BITS-1:0] = I_FLASH_WORD;

	genvar g;
	generate
		for (g = 0; g < STAGE_COUNT; g++) begin : g_delay
			localparam int D = ALIGN_DEPTH - g / 2;
			logic [WORD_BITS-1:0] taps [D];
			logic [WORD_BITS-1:0] next_taps [D];
			always_comb begin
				next_taps[0] = I_STAGE_WORDS[g*WORD_BITS +: WORD_BITS];
				for (int k = 1; k < D; k++) begin
					next_taps[k] = taps[k-1];
				end
			end
			always_ff @(posedge I_CLOCK) begin
				for (int k = 0; k < D; k++) begin
					taps[k] <= I_RESET ? WORD_RESET : next_taps[k];
				end
			end
			// Stage 0 lands in the top word of the vector
			assign aligned[(STAGE_COUNT-g)*WORD_BITS +: WORD_BITS] = taps[D-1];
		end
	endgenerate

	// Overlapped addition: each word weighs twice the next, so the extra bit absorbs errors
	logic [SUM_BITS-1:0] sum;
	logic [RESULT_BITS-1:0] corrected;

	always_comb begin
		sum = '0;
		for (int m = 0; m <= STAGE_COUNT; m++) begin
			sum = SUM_BITS'(sum + (SUM_BITS'(aligned[(STAGE_COUNT-m)*WORD_BITS +: WORD_BITS])
				<< (STAGE_COUNT - m)));
		end
		// Saturate at full scale rather than wrap on an over-range code
		corrected = sum[SUM_BITS-1] ? RESULT_MAX : sum[RESULT_BITS-1:0];
	end

	// Fill tracker: the vector is whole once the deepest delay has filled
	logic [ALIGN_DEPTH-1:0] fill;
	logic [ALIGN_DEPTH-1:0] next_fill;

	always_comb begin
		next_fill = {fill[ALIGN_DEPTH-2:0], 1'b1};
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			fill <= '0;
		end else begin
			fill <= next_fill;
		end
	end

	// Buffer between correction and the output registers
	logic push_ready;
	logic pop_valid;
	logic [RESULT_BITS-1:0] pop_data;
	logic pop_ready;

	// Hold from the capture side stalls draining; data lost only once full
	assign pop_ready = !hold_sync;

	adc_result_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_ENTRIES)
	) u_fifo (
		.i_clock(I_CLOCK),
		.i_reset(I_RESET),
		.i_push_valid(fill[ALIGN_DEPTH-1]),
		.o_push_ready(push_ready),
		.i_push_data(corrected),
		.o_pop_valid(pop_valid),
		.i_pop_ready(pop_ready),
		.o_pop_data(pop_data)
	);

	// Double-buffered output
	logic [RESULT_BITS-1:0] stage_one;
	logic stage_one_valid;
	logic [RESULT_BITS-1:0] next_stage_one;
	logic next_stage_one_valid;
	logic [RESULT_BITS-1:0] next_result;
	logic next_result_valid;
	logic [RESULT_BITS-1:0] formatted;
	logic next_buffer_ready;

	// Format applied on leaving the buffer, so a pin change reaches only later words
	always_comb begin
		formatted = pop_data;
		if (fmt_sync) begin
			formatted = pop_data ^ MSB_FLIP;
		end
		next_buffer_ready = push_ready;
		next_stage_one = stage_one;
		next_stage_one_valid = stage_one_valid;
		next_result = O_RESULT;
		next_result_valid = O_RESULT_VALID;
		// Both output registers freeze together while held
		if (pop_ready) begin
			next_stage_one = formatted;
			next_stage_one_valid = pop_valid;
			next_result = stage_one;
			next_result_valid = stage_one_valid;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			stage_one <= RESULT_RESET;
			stage_one_valid <= 1'b0;
			O_RESULT <= RESULT_RESET;
			O_RESULT_VALID <= 1'b0;
			O_BUFFER_READY <= 1'b0;
		end else begin
			stage_one <= next_stage_one;
			stage_one_valid <= next_stage_one_valid;
			O_RESULT <= next_result;
			O_RESULT_VALID <= next_result_valid;
			O_BUFFER_READY <= next_buffer_ready;
		end
	end
endmodule : adc_correction
